// ===== hdl/ppcf_consts.vh
// Offsets, field positions, reset values and timing counts of the position command front end
`ifndef PPCF_CONSTS_VH
`define PPCF_CONSTS_VH
`define PPCF_REG_CFG0 12'h000
`define PPCF_REG_DIV 12'h004
`define PPCF_REG_GEAR 12'h008
`define PPCF_REG_SOFT 12'h00c
`define PPCF_REG_TURN 12'h010
`define PPCF_REG_SCALE 12'h014
`define PPCF_REG_CTRL 12'h018
`define PPCF_REG_STAT 12'h01c
`define PPCF_REG_DEV 12'h020
`define PPCF_REG_TURNS 12'h024
`define PPCF_REG_ENCRES 12'h028
`define PPCF_CLR_COND_LSB 0
`define PPCF_CLR_POL_LSB 2
`define PPCF_FILT_SEL_BIT 4
`define PPCF_CMD_FILT_BIT 5
`define PPCF_CL_MODE_LSB 8
`define PPCF_CLR_COND_RST 2'h1
`define PPCF_CLR_POL_RST 2'h0
`define PPCF_FILT_SEL_RST 1'h1
`define PPCF_DIV_RST 16'h03e8
`define PPCF_DIV_MIN 16'h0010
`define PPCF_DIV_MAX 16'h4000
`define PPCF_GEAR_NUM_RST 16'h0004
`define PPCF_GEAR_DEN_RST 16'h0001
`define PPCF_SOFT_RST 13'h0000
`define PPCF_SOFT_MAX 13'h1900
`define PPCF_TURN_RST 16'hffff
`define PPCF_SCALE_RST 16'h4000
`define PPCF_SCALE_MIN 16'h0201
`define PPCF_ENCRES_RST 16'h4000
`define PPCF_CLK_MHZ 200
`define PPCF_STEP_NS 10000
`define PPCF_STEP_CYC (`PPCF_STEP_NS * `PPCF_CLK_MHZ / 1000)
`define PPCF_LD_NS 2000
`define PPCF_OC_NS 5000
`define PPCF_LD_CYC (`PPCF_LD_NS * `PPCF_CLK_MHZ / 1000 / 4)
`define PPCF_OC_CYC (`PPCF_OC_NS * `PPCF_CLK_MHZ / 1000 / 4)
`endif

// ===== hdl/ppcf_pulse_filter.v
// Glitch filter for the command pulse input with two selectable pass widths
module ppcf_pulse_filter #(
  parameter integer LD_CYC = 100,
  parameter integer OC_CYC = 250
) (
  input wire pclk,
  input wire presetn,
  input wire sel_open_collector,
  input wire din,
  output reg dout
);
  reg [8:0] cnt_q;
  wire [8:0] lim;
  assign lim = sel_open_collector ? OC_CYC[8:0] : LD_CYC[8:0];
  // Output follows the input only after it has stood stable for the selected width
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 9'h000;
      dout <= 1'b0;
    end else if (din == dout) begin
      cnt_q <= 9'h000;
    end else if (cnt_q >= lim - 9'h001) begin
      cnt_q <= 9'h000;
      dout <= din;
    end else begin
      cnt_q <= cnt_q + 9'h001;
    end
  end
endmodule

// ===== hdl/ppcf_top.v
// Position command front end: clear logic, gear, soft start, divider, turn count, APB registers
//
// Local design decisions: the register offsets and the APB register port.
`include "ppcf_consts.vh"
module ppcf_top #(
  parameter integer DEV_W = 32,
  parameter integer TURN_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire cmd_pulse,
  input wire cmd_dir,
  input wire deviation_clear_input,
  input wire servo_on,
  input wire alarm_in,
  input wire fb_pulse,
  input wire fb_dir,
  input wire position_send_request,
  input wire abs_encoder,
  output reg motor_step,
  output reg motor_dir,
  output reg enc_out_pulse,
  output reg enc_out_dir,
  output reg [TURN_W-1:0] turn_count_out,
  output reg turn_count_valid,
  output wire turn_limit_mismatch_alarm,
  output wire param_error_alarm
);
  function [15:0] ppcf_clamp16;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if (v < lo)
        ppcf_clamp16 = lo;
      else if (v > hi)
        ppcf_clamp16 = hi;
      else
        ppcf_clamp16 = v;
    end
  endfunction

  // Pending (software-written) and active configuration
  reg [1:0] clear_input_condition_p_q, clear_on_stop_policy_p_q, closed_loop_usage_mode_p_q;
  reg pulse_input_filter_select_p_q, command_filter_type_p_q;
  reg [15:0] output_pulse_divide_rate_p_q, gear_num_value_p_q, gear_den_value_p_q;
  reg [15:0] turn_count_limit_p_q, closed_loop_scale_p_q, enc_res_p_q;
  reg [12:0] soft_start_time_constant_q;
  reg [1:0] clear_input_condition, clear_on_stop_policy, closed_loop_usage_mode;
  reg pulse_input_filter_select, command_filter_type;
  reg [15:0] output_pulse_divide_rate, gear_numerator, gear_denominator;
  reg [15:0] turn_count_limit, closed_loop_scale, enc_res;
  reg [15:0] enc_turn_limit_q;
  reg cfg_loaded_q;

  // APB: zero wait states
  wire apb_wr;
  assign apb_wr = psel & penable & pwrite;
  assign pready = 1'b1;
  reg addr_ok;
  always @* begin
    case (paddr)
      `PPCF_REG_CFG0, `PPCF_REG_DIV, `PPCF_REG_GEAR, `PPCF_REG_SOFT, `PPCF_REG_TURN,
      `PPCF_REG_SCALE, `PPCF_REG_CTRL, `PPCF_REG_STAT, `PPCF_REG_DEV, `PPCF_REG_TURNS,
      `PPCF_REG_ENCRES: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;
  wire ctrl_wr;
  assign ctrl_wr = apb_wr & (paddr == `PPCF_REG_CTRL);
  // CTRL bit 1 acts as a power restart: pending fields become active
  wire cfg_load;
  assign cfg_load = ~cfg_loaded_q | (ctrl_wr & pwdata[1]);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_input_condition_p_q <= `PPCF_CLR_COND_RST;
      clear_on_stop_policy_p_q <= `PPCF_CLR_POL_RST;
      pulse_input_filter_select_p_q <= `PPCF_FILT_SEL_RST;
      command_filter_type_p_q <= 1'b0;
      closed_loop_usage_mode_p_q <= 2'h0;
      output_pulse_divide_rate_p_q <= `PPCF_DIV_RST;
      gear_num_value_p_q <= `PPCF_GEAR_NUM_RST;
      gear_den_value_p_q <= `PPCF_GEAR_DEN_RST;
      soft_start_time_constant_q <= `PPCF_SOFT_RST;
      turn_count_limit_p_q <= `PPCF_TURN_RST;
      closed_loop_scale_p_q <= `PPCF_SCALE_RST;
      enc_res_p_q <= `PPCF_ENCRES_RST;
    end else if (apb_wr) begin
      case (paddr)
        `PPCF_REG_CFG0: begin
          clear_input_condition_p_q <= pwdata[`PPCF_CLR_COND_LSB +: 2];
          if (pwdata[`PPCF_CLR_POL_LSB +: 2] != 2'h3)
            clear_on_stop_policy_p_q <= pwdata[`PPCF_CLR_POL_LSB +: 2];
          pulse_input_filter_select_p_q <= pwdata[`PPCF_FILT_SEL_BIT];
          command_filter_type_p_q <= pwdata[`PPCF_CMD_FILT_BIT];
          closed_loop_usage_mode_p_q <= pwdata[`PPCF_CL_MODE_LSB +: 2];
        end
        `PPCF_REG_DIV: output_pulse_divide_rate_p_q <= pwdata[15:0];
        `PPCF_REG_GEAR: begin
          if (pwdata[15:0] != 16'h0000)
            gear_num_value_p_q <= pwdata[15:0];
          if (pwdata[31:16] != 16'h0000)
            gear_den_value_p_q <= pwdata[31:16];
        end
        `PPCF_REG_SOFT: soft_start_time_constant_q <= (pwdata[12:0] > `PPCF_SOFT_MAX) ?
          `PPCF_SOFT_MAX : pwdata[12:0];
        `PPCF_REG_TURN: turn_count_limit_p_q <= pwdata[15:0];
        `PPCF_REG_SCALE: closed_loop_scale_p_q <= (pwdata[15:0] < 16'h0019) ?
          16'h0019 : pwdata[15:0];
        `PPCF_REG_ENCRES: enc_res_p_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Active configuration latched after reset release and on each CTRL bit 1 write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_loaded_q <= 1'b0;
      clear_input_condition <= `PPCF_CLR_COND_RST;
      clear_on_stop_policy <= `PPCF_CLR_POL_RST;
      pulse_input_filter_select <= `PPCF_FILT_SEL_RST;
      command_filter_type <= 1'b0;
      closed_loop_usage_mode <= 2'h0;
      output_pulse_divide_rate <= `PPCF_DIV_RST;
      gear_numerator <= `PPCF_GEAR_NUM_RST;
      gear_denominator <= `PPCF_GEAR_DEN_RST;
      turn_count_limit <= `PPCF_TURN_RST;
      closed_loop_scale <= `PPCF_SCALE_RST;
      enc_res <= `PPCF_ENCRES_RST;
    end else if (cfg_load) begin
      cfg_loaded_q <= 1'b1;
      clear_input_condition <= clear_input_condition_p_q;
      clear_on_stop_policy <= clear_on_stop_policy_p_q;
      pulse_input_filter_select <= pulse_input_filter_select_p_q;
      command_filter_type <= command_filter_type_p_q;
      closed_loop_usage_mode <= closed_loop_usage_mode_p_q;
      output_pulse_divide_rate <= output_pulse_divide_rate_p_q;
      gear_numerator <= gear_num_value_p_q;
      gear_denominator <= gear_den_value_p_q;
      turn_count_limit <= turn_count_limit_p_q;
      closed_loop_scale <= closed_loop_scale_p_q;
      enc_res <= enc_res_p_q;
    end
  end

  // Pin synchronisers
  reg [5:0] sync1_q, sync2_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {position_send_request, fb_dir, fb_pulse, deviation_clear_input,
                  cmd_dir, cmd_pulse};
      sync2_q <= sync1_q;
    end
  end
  wire cmd_filt;
  ppcf_pulse_filter #(
    .LD_CYC(`PPCF_LD_CYC),
    .OC_CYC(`PPCF_OC_CYC)
  ) u_filt (
    .pclk(pclk),
    .presetn(presetn),
    .sel_open_collector(pulse_input_filter_select),
    .din(sync2_q[0]),
    .dout(cmd_filt)
  );

  reg cmd_filt_d1_q, clr_in_d1_q, fb_d1_q, send_d1_q, servo_d1_q, alarm_d1_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_filt_d1_q <= 1'b0;
      clr_in_d1_q <= 1'b0;
      fb_d1_q <= 1'b0;
      send_d1_q <= 1'b0;
      servo_d1_q <= 1'b0;
      alarm_d1_q <= 1'b0;
    end else begin
      cmd_filt_d1_q <= cmd_filt;
      clr_in_d1_q <= sync2_q[2];
      fb_d1_q <= sync2_q[3];
      send_d1_q <= sync2_q[5];
      servo_d1_q <= servo_on;
      alarm_d1_q <= alarm_in;
    end
  end
  wire cmd_edge, fb_edge;
  assign cmd_edge = cmd_filt & ~cmd_filt_d1_q;
  assign fb_edge = sync2_q[3] & ~fb_d1_q;

  // Clear qualification
  reg clr_ext;
  always @* begin
    case (clear_input_condition)
      2'h0: clr_ext = sync2_q[2];
      2'h1: clr_ext = sync2_q[2] & ~clr_in_d1_q;
      2'h2: clr_ext = ~sync2_q[2];
      default: clr_ext = ~sync2_q[2] & clr_in_d1_q;
    endcase
  end
  reg clr_stop;
  always @* begin
    case (clear_on_stop_policy)
      2'h0: clr_stop = ~servo_on | alarm_in;
      2'h2: clr_stop = alarm_in;
      default: clr_stop = 1'b0;
    endcase
  end
  wire dev_clear;
  assign dev_clear = clr_ext | clr_stop;

  // Electronic gear: accumulate numerator per pulse, emit a step per denominator
  reg [16:0] gear_acc_q;
  reg [16:0] gear_sum;
  always @* begin
    gear_sum = gear_acc_q;
    if (cmd_edge)
      gear_sum = gear_acc_q + {1'b0, gear_numerator};
  end
  // Soft start: first-order filter on the pending scaled pulses
  reg [DEV_W-1:0] cmd_pend_q;
  reg [12:0] tc_cnt_q;
  reg [11:0] step_cnt_q;
  wire tc_active;
  assign tc_active = (command_filter_type == 1'b0) &&
                     (soft_start_time_constant_q != 13'h0000);
  wire release_tick;
  assign release_tick = ~tc_active | (tc_cnt_q == 13'h0000);
  wire [DEV_W-1:0] release_n;
  // Exponential release: a fraction of pending work each time-constant tick
  assign release_n = tc_active ? ((cmd_pend_q >> 3) | {{(DEV_W-1){1'b0}}, |cmd_pend_q})
                               : cmd_pend_q;
  wire [DEV_W-1:0] released;
  assign released = release_tick ? release_n : {DEV_W{1'b0}};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gear_acc_q <= 17'h00000;
      cmd_pend_q <= {DEV_W{1'b0}};
      tc_cnt_q <= 13'h0000;
      step_cnt_q <= 12'h000;
    end else begin
      if (gear_sum >= {1'b0, gear_denominator}) begin
        gear_acc_q <= gear_sum - {1'b0, gear_denominator};
        cmd_pend_q <= cmd_pend_q - released + {{(DEV_W-1){1'b0}}, 1'b1};
      end else begin
        gear_acc_q <= gear_sum;
        cmd_pend_q <= cmd_pend_q - released;
      end
      if (step_cnt_q == `PPCF_STEP_CYC - 1) begin
        step_cnt_q <= 12'h000;
        tc_cnt_q <= (tc_cnt_q == 13'h0000) ? soft_start_time_constant_q : tc_cnt_q - 13'h0001;
      end else begin
        step_cnt_q <= step_cnt_q + 12'h001;
      end
    end
  end

  // Deviation counter, counted in x4 feedback units
  reg [DEV_W-1:0] dev_q;
  wire [DEV_W-1:0] fb_delta;
  assign fb_delta = fb_edge ? {{(DEV_W-1){1'b0}}, 1'b1} : {DEV_W{1'b0}};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      dev_q <= {DEV_W{1'b0}};
    else if (dev_clear)
      dev_q <= {DEV_W{1'b0}};
    else
      dev_q <= dev_q + (sync2_q[1] ? -released : released) +
               (sync2_q[4] ? fb_delta : -fb_delta);
  end

  // Motor drive: a step per cycle while servo on and deviation nonzero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_step <= 1'b0;
      motor_dir <= 1'b0;
    end else begin
      motor_step <= servo_on & (dev_q != {DEV_W{1'b0}});
      motor_dir <= dev_q[DEV_W-1];
    end
  end

  // Encoder output divider: x4 feedback edges scaled by rate over four times resolution
  wire [15:0] res_eff;
  assign res_eff = ppcf_clamp16(enc_res, `PPCF_DIV_MIN, 16'hffff);
  wire [15:0] div_eff;
  assign div_eff = ppcf_clamp16(output_pulse_divide_rate, `PPCF_DIV_MIN,
                   (res_eff < `PPCF_DIV_MAX) ? res_eff : `PPCF_DIV_MAX);
  reg [17:0] div_acc_q;
  wire [17:0] div_sum;
  assign div_sum = div_acc_q + {2'b00, div_eff};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_acc_q <= 18'h00000;
      enc_out_pulse <= 1'b0;
      enc_out_dir <= 1'b0;
    end else begin
      enc_out_pulse <= 1'b0;
      enc_out_dir <= sync2_q[4];
      if (cfg_load) begin
        div_acc_q <= 18'h00000;
      end else if (fb_edge) begin
        if (div_sum >= {res_eff, 2'b00}) begin
          div_acc_q <= div_sum - {res_eff, 2'b00};
          enc_out_pulse <= 1'b1;
        end else begin
          div_acc_q <= div_sum;
        end
      end
    end
  end

  // Multi-turn counter
  reg [TURN_W-1:0] turns_q;
  reg [17:0] rev_pos_q;
  wire limit_default;
  assign limit_default = (turn_count_limit == `PPCF_TURN_RST);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      turns_q <= {TURN_W{1'b0}};
      rev_pos_q <= 18'h00000;
      turn_count_out <= {TURN_W{1'b0}};
      turn_count_valid <= 1'b0;
    end else begin
      turn_count_valid <= 1'b0;
      if (cfg_load) begin
        rev_pos_q <= 18'h00000;
      end else if (fb_edge) begin
        if (!sync2_q[4]) begin
          if (rev_pos_q == {res_eff, 2'b00} - 18'h00001) begin
            rev_pos_q <= 18'h00000;
            if (!limit_default && turns_q >= turn_count_limit)
              turns_q <= {TURN_W{1'b0}};
            else
              turns_q <= turns_q + {{(TURN_W-1){1'b0}}, 1'b1};
          end else begin
            rev_pos_q <= rev_pos_q + 18'h00001;
          end
        end else begin
          if (rev_pos_q == 18'h00000) begin
            rev_pos_q <= {res_eff, 2'b00} - 18'h00001;
            if (!limit_default && turns_q == {TURN_W{1'b0}})
              turns_q <= turn_count_limit;
            else
              turns_q <= turns_q - {{(TURN_W-1){1'b0}}, 1'b1};
          end else begin
            rev_pos_q <= rev_pos_q - 18'h00001;
          end
        end
      end
      if (abs_encoder && sync2_q[5] && !send_d1_q) begin
        turn_count_out <= turns_q;
        turn_count_valid <= 1'b1;
      end
    end
  end

  // Encoder-side limit agreement
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      enc_turn_limit_q <= `PPCF_TURN_RST;
    else if (ctrl_wr && pwdata[0])
      enc_turn_limit_q <= turn_count_limit;
  end
  assign turn_limit_mismatch_alarm = cfg_loaded_q &&
                                     (enc_turn_limit_q != turn_count_limit);
  assign param_error_alarm = cfg_loaded_q && (closed_loop_usage_mode != 2'h0) &&
                             (closed_loop_scale < `PPCF_SCALE_MIN);

  // Read mux
  always @* begin
    prdata = 32'h00000000;
    if (psel && !pwrite) begin
      case (paddr)
        `PPCF_REG_CFG0: prdata = {22'h000000, closed_loop_usage_mode_p_q, 2'b00,
          command_filter_type_p_q, pulse_input_filter_select_p_q, clear_on_stop_policy_p_q,
          clear_input_condition_p_q};
        `PPCF_REG_DIV: prdata = {16'h0000, output_pulse_divide_rate_p_q};
        `PPCF_REG_GEAR: prdata = {gear_den_value_p_q, gear_num_value_p_q};
        `PPCF_REG_SOFT: prdata = {19'h00000, soft_start_time_constant_q};
        `PPCF_REG_TURN: prdata = {16'h0000, turn_count_limit_p_q};
        `PPCF_REG_SCALE: prdata = {16'h0000, closed_loop_scale_p_q};
        `PPCF_REG_STAT: prdata = {28'h0000000, servo_d1_q, alarm_d1_q, param_error_alarm,
          turn_limit_mismatch_alarm};
        `PPCF_REG_DEV: prdata = dev_q;
        `PPCF_REG_TURNS: prdata = {16'h0000, turns_q};
        `PPCF_REG_ENCRES: prdata = {16'h0000, enc_res_p_q};
        default: prdata = 32'h00000000;
      endcase
    end
  end
endmodule

// ===== verification/ppcf_asserts.sv
// Concurrent checks on the ports of the position command front end
module ppcf_asserts #(
  parameter integer DEV_W = 32,
  parameter integer TURN_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire cmd_pulse,
  input wire cmd_dir,
  input wire deviation_clear_input,
  input wire servo_on,
  input wire alarm_in,
  input wire fb_pulse,
  input wire fb_dir,
  input wire position_send_request,
  input wire abs_encoder,
  input wire motor_step,
  input wire motor_dir,
  input wire enc_out_pulse,
  input wire enc_out_dir,
  input wire [TURN_W-1:0] turn_count_out,
  input wire turn_count_valid,
  input wire turn_limit_mismatch_alarm,
  input wire param_error_alarm
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_unmapped_err: assert property (psel && penable && paddr > 12'h028
    |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && penable && paddr <= 12'h028 && paddr[1:0] == 2'h0
    |-> pready && !pslverr) else $error("mapped access refused");
  a_servo_off_idle: assert property (!servo_on [*2] |-> !motor_step)
    else $error("motor steps while servo off");
  a_alarm_idle: assert property (alarm_in [*3] |-> !motor_step)
    else $error("motor steps during alarm");
  a_send_valid: assert property ($rose(position_send_request) && abs_encoder
    |-> ##[3:5] turn_count_valid) else $error("turn count not sent");
  a_valid_single: assert property (turn_count_valid |=> !turn_count_valid)
    else $error("turn count valid longer than one cycle");
  a_enc_single: assert property (enc_out_pulse |=> !enc_out_pulse)
    else $error("encoder output pulse too long");
  a_limit_agree: assert property ($rose(turn_limit_mismatch_alarm)
    |-> $past(psel && penable && pwrite && paddr == 12'h018 && pwdata[1]))
    else $error("turn limit mismatch without a limit reload");
  a_limit_clear: assert property ($fell(turn_limit_mismatch_alarm)
    |-> $past(psel && penable && pwrite && paddr == 12'h018 && pwdata[1:0] != 2'b00))
    else $error("turn limit mismatch cleared without update");
  a_scale_ok: assert property (!param_error_alarm)
    else $error("parameter error with default scale");
endmodule
bind ppcf_top ppcf_asserts #(.DEV_W(DEV_W), .TURN_W(TURN_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir), .deviation_clear_input(deviation_clear_input),
  .servo_on(servo_on), .alarm_in(alarm_in), .fb_pulse(fb_pulse), .fb_dir(fb_dir),
  .position_send_request(position_send_request), .abs_encoder(abs_encoder),
  .motor_step(motor_step), .motor_dir(motor_dir), .enc_out_pulse(enc_out_pulse),
  .enc_out_dir(enc_out_dir), .turn_count_out(turn_count_out),
  .turn_count_valid(turn_count_valid), .turn_limit_mismatch_alarm(turn_limit_mismatch_alarm),
  .param_error_alarm(param_error_alarm));

// ===== verification/ppcf_ctrl_model.sv
// External position controller: command pulse train and deviation clear pin
module ppcf_ctrl_model (
  input wire pclk,
  output logic cmd_pulse,
  output logic cmd_dir,
  output logic deviation_clear_input
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cmd_pulse = 1'b0;
    cmd_dir = 1'b0;
    deviation_clear_input = 1'b0;
  end
  // Period of 525 + hi cycles; hi of 520 gives 1045 cycles, which keeps the train under 200 kpps
  task send(input int n, input logic dir, input int hi);
    repeat (n) begin
      @(posedge pclk);
      cmd_dir <= dir;
      repeat (4) @(posedge pclk);
      cmd_pulse <= 1'b1;
      repeat (hi) @(posedge pclk);
      cmd_pulse <= 1'b0;
      repeat (520) @(posedge pclk);
    end
  endtask
  task set_clear(input logic v);
    @(posedge pclk);
    deviation_clear_input <= v;
    repeat (8) @(posedge pclk);
  endtask
endmodule

// ===== verification/tb_pulse_position_command_frontend.sv
// Register and pulse path tests of the position command front end
module tb_pulse_position_command_frontend;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic servo_on = 1'b0;
  logic alarm_in = 1'b0;
  logic fb_pulse = 1'b0;
  logic fb_dir = 1'b0;
  logic position_send_request = 1'b0;
  logic abs_encoder = 1'b1;
  wire cmd_pulse, cmd_dir, deviation_clear_input;
  wire [31:0] prdata;
  wire pready, pslverr, motor_step, motor_dir, enc_out_pulse, enc_out_dir;
  wire turn_count_valid, turn_limit_mismatch_alarm, param_error_alarm;
  wire [15:0] turn_count_out;
  int err_total = 0;
  int num_checks = 0;
  int enc_cnt = 0;
  logic [31:0] rd;
  logic er;
  logic seen;
  logic [11:0] ra [7] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h028};
  logic [31:0] rv [7] = '{32'h11, 32'h3e8, 32'h10004, 32'h0, 32'hffff, 32'h4000, 32'h4000};
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (enc_out_pulse === 1'b1) enc_cnt <= enc_cnt + 1;
  end
  ppcf_ctrl_model u_ctl (.pclk(pclk), .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir),
    .deviation_clear_input(deviation_clear_input));
  ppcf_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir),
    .deviation_clear_input(deviation_clear_input), .servo_on(servo_on), .alarm_in(alarm_in),
    .fb_pulse(fb_pulse), .fb_dir(fb_dir), .position_send_request(position_send_request),
    .abs_encoder(abs_encoder), .motor_step(motor_step), .motor_dir(motor_dir),
    .enc_out_pulse(enc_out_pulse), .enc_out_dir(enc_out_dir), .turn_count_out(turn_count_out),
    .turn_count_valid(turn_count_valid), .turn_limit_mismatch_alarm(turn_limit_mismatch_alarm),
    .param_error_alarm(param_error_alarm));
  task final_report;
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      err_total++;
      final_report();
    end
  endtask
  task fb(input int n);
    repeat (n) begin
      @(posedge pclk);
      fb_pulse <= 1'b1;
      repeat (4) @(posedge pclk);
      fb_pulse <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
  endtask
  task dev(input logic [31:0] exp);
    apb(1'b0, 12'h020, 32'h0);
    chk32(rd, exp);
  endtask
  task turns_req(input logic [15:0] exp);
    seen = 1'b0;
    position_send_request <= 1'b1;
    repeat (8) begin
      @(posedge pclk);
      if (turn_count_valid === 1'b1) seen = 1'b1;
    end
    position_send_request <= 1'b0;
    chk1(seen, 1'b1);
    chk32({16'h0000, turn_count_out}, {16'h0000, exp});
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk32(rd, rv[i]);
      chk1(er, 1'b0);
    end
    apb(1'b0, 12'h02c, 32'h0);
    chk32(rd, 32'h0);
    chk1(er, 1'b1);
    apb(1'b1, 12'h030, 32'hffffffff);
    chk1(er, 1'b1);
    apb(1'b0, 12'h01c, 32'h0);
    chk32(rd, 32'h0);
    servo_on <= 1'b1;
    apb(1'b0, 12'h01c, 32'h0);
    chk32(rd, 32'h8);
    u_ctl.send(3, 1'b0, 520);
    u_ctl.send(1, 1'b1, 520);
    dev(32'h8);
    chk1(motor_step, 1'b1);
    chk1(motor_dir, 1'b0);
    fb(2);
    dev(32'h6);
    u_ctl.set_clear(1'b1);
    dev(32'h0);
    u_ctl.send(1, 1'b0, 520);
    dev(32'h4);
    u_ctl.set_clear(1'b0);
    dev(32'h4);
    u_ctl.send(1, 1'b0, 150);
    dev(32'h4);
    apb(1'b1, 12'h000, 32'h4);
    apb(1'b1, 12'h018, 32'h1);
    apb(1'b0, 12'h01c, 32'h0);
    chk32(rd, 32'h8);
    servo_on <= 1'b0;
    repeat (4) @(posedge pclk);
    dev(32'h0);
    chk1(motor_step, 1'b0);
    servo_on <= 1'b1;
    u_ctl.send(1, 1'b0, 520);
    dev(32'h4);
    alarm_in <= 1'b1;
    repeat (5) @(posedge pclk);
    alarm_in <= 1'b0;
    dev(32'h0);
    turns_req(16'h0000);
    apb(1'b1, 12'h010, 32'h5);
    apb(1'b1, 12'h028, 32'h10);
    apb(1'b1, 12'h018, 32'h2);
    apb(1'b0, 12'h01c, 32'h0);
    chk32(rd, 32'h9);
    apb(1'b1, 12'h018, 32'h1);
    apb(1'b0, 12'h01c, 32'h0);
    chk32(rd, 32'h8);
    u_ctl.send(1, 1'b0, 150);
    dev(32'h4);
    servo_on <= 1'b0;
    repeat (4) @(posedge pclk);
    dev(32'h4);
    servo_on <= 1'b1;
    repeat (2) @(posedge pclk);
    chk1(motor_step, 1'b1);
    u_ctl.set_clear(1'b1);
    u_ctl.send(1, 1'b0, 520);
    dev(32'h0);
    u_ctl.set_clear(1'b0);
    fb(8);
    chk32(enc_cnt, 32'h2);
    chk1(enc_out_dir, 1'b0);
    fb(312);
    apb(1'b0, 12'h024, 32'h0);
    chk32(rd, 32'h5);
    turns_req(16'h0005);
    fb(64);
    apb(1'b0, 12'h024, 32'h0);
    chk32(rd, 32'h0);
    repeat (8) @(posedge pclk);
    final_report();
  end
endmodule
